/* File: hdl/tcc_pkg.sv */
// shared constants for the terminal control code interpreter
// assumes a 125 MHz system clock and 7-bit character codes
package tcc_pkg;
  localparam int unsigned CLK_KHZ  = 125000;
  localparam int unsigned ALARM_MS = 500;  // bell tone length
  localparam int unsigned RPT_MS   = 200;  // five codes per second

  localparam int PW = 17;  // synchronised pin vector
  localparam int P_CODE = 0;
  localparam int P_DOWN = 7;
  localparam int P_ESC  = 8;
  localparam int P_CTL  = 9;
  localparam int P_RPT  = 10;
  localparam int P_AUTO = 11;
  localparam int P_LF2  = 12;
  localparam int P_INH  = 13;
  localparam int P_LOC  = 14;
  localparam int P_CTS  = 15;
  localparam int P_DSR  = 16;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_MSG  = 8'h08;
  localparam int CTRL_W = 13;
  localparam int B_TA = 0;  // line turnaround fitted
  localparam int B_TAB = 1;  // horizontal tab fitted
  localparam int B_AB = 2;  // answerback fitted
  localparam int B_VT = 3;  // vertical tab / form feed fitted
  localparam int B_STRAP = 4;  // local motor/suppress codes act
  localparam int B_EOT = 5;  // EOT recognised
  localparam int B_OK = 6;  // able to accept a message
  localparam int MLEN_LO = 8;
  localparam int S_CLR = 12;  // status write: clear interrupt lamp
  localparam int M_IDX_LO = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0020;

  localparam int NCOL = 80;
  localparam logic [6:0] COL_LAST = 7'h4F;
  localparam logic [6:0] COL_STEP = 7'h01;
  localparam int MSG_DEPTH = 20;
  localparam logic [4:0] MSG_MAX = 5'h14;
  localparam logic [4:0] MIDX_STEP = 5'h01;
  localparam logic [1:0] LINES_1 = 2'h1;
  localparam logic [1:0] LINES_2 = 2'h2;

  localparam logic [6:0] C_ETX = 7'h03;
  localparam logic [6:0] C_EOT = 7'h04;
  localparam logic [6:0] C_ENQ = 7'h05;
  localparam logic [6:0] C_ACK = 7'h06;
  localparam logic [6:0] C_BEL = 7'h07;
  localparam logic [6:0] C_BS  = 7'h08;
  localparam logic [6:0] C_HT  = 7'h09;
  localparam logic [6:0] C_LF  = 7'h0A;
  localparam logic [6:0] C_VT  = 7'h0B;
  localparam logic [6:0] C_FF  = 7'h0C;
  localparam logic [6:0] C_CR  = 7'h0D;
  localparam logic [6:0] C_DLE = 7'h10;
  localparam logic [6:0] C_NAK = 7'h15;
  localparam logic [6:0] C_ESC = 7'h1B;
  localparam logic [6:0] C_SP  = 7'h20;
  localparam logic [6:0] C_DEL = 7'h7F;
  localparam logic [6:0] C_0   = 7'h30;
  localparam logic [6:0] C_1   = 7'h31;
  localparam logic [6:0] C_2   = 7'h32;
  localparam logic [6:0] C_COL = 7'h3A;
  localparam logic [6:0] C_SEM = 7'h3B;
  localparam logic [6:0] C_QM  = 7'h3F;
  localparam logic [6:0] C_UH  = 7'h48;
  localparam logic [6:0] C_UJ  = 7'h4A;
  localparam logic [6:0] C_LH  = 7'h68;
  localparam logic [6:0] C_LJ  = 7'h6A;
  localparam logic [6:0] CTL_MASK = 7'h1F;

  typedef enum logic [1:0] {
    TX_IDLE   = 2'b00,
    TX_SECOND = 2'b01,
    TX_MSG    = 2'b10,
    TX_LOAD   = 2'b11
  } tcc_tx_t;
endpackage

/* File: hdl/tcc_msg_mem.sv */
// answerback message store, one write port and a registered read port
// assumes writes come from the bus slave in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module tcc_msg_mem
  import tcc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       ce_i,
  input  wire logic       we_i,
  input  wire logic [4:0] waddr_i,
  input  wire logic [6:0] wdata_i,
  input  wire logic [4:0] raddr_i,
  output logic      [6:0] rdata_o
);
  logic [6:0] mem [MSG_DEPTH];

  // no reset: contents are whatever software last loaded
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i && waddr_i < MSG_MAX) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= (raddr_i < MSG_MAX) ? mem[raddr_i] : C_SP;
    end
  end
endmodule // tcc_msg_mem
`default_nettype wire

/* File: hdl/tcc_top.sv */
// keyboard code generation and control code interpreter of a printing terminal
// assumes a Wishbone classic master, a UART on clk_i, panel and modem pins async
// Functional notes
// R1: keyboard issues any 7-bit code, one code at a time only
// R2: tone pulse on each key press, not for escape, control or repeat keys
// R3: escape sent only with a second key; control key alters the other code
// R4: repeat key reissues held key at most five codes per second
// R5: auto newline switch makes return send CR then LF, else CR only
// R6: undefined control codes ignored; receipt-only actions need line input
// R7: with turnaround, local ETX goes to receive, received ETX to transmit
// R8: EOT stops motor and drops request to send
// R9: received ENQ with clear to send sends answerback, then ACK/NAK and turns
// R10: with turnaround ACK turns the line; ENQ answered ACK when able to accept
// R11: BEL sounds alarm half a second; BEL during tone ignored
// R12: backspace moves print column left by one
// R13: HT goes to next tab stop or line end; ignored without tab option
// R14: LF advances one or two lines; VT and FF pulse with option fitted
// R15: CR to column zero, or leftmost tab stop with tab option
// R16: DLE EOT drops terminal ready until set ready goes off, and stops motor
// R17: received DLE ? suppresses print, darkens ready lamp, replies ENQ
// R18: received NAK turns line, lights interrupt lamp, disables keyboard
// R19: ESC 1 sets tab, ESC 2 clears all, ESC 0 pulses reader reverse
// R20: received ESC ; suppresses local print; ESC :, inhibit, local restore
// R21: received ESC H/J switch motor; strap lets local codes act too
// R22: sender waits for motor start and stop; no timing enforced here
// R23: reset clears every tab stop
//
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tcc_top
  import tcc_pkg::*;
#(
  parameter int unsigned ALARM_CYC = ALARM_MS * CLK_KHZ,
  parameter int unsigned RPT_CYC   = RPT_MS * CLK_KHZ
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [6:0]  key_code_i,
  input  wire logic        key_down_i,
  input  wire logic        esc_key_i,
  input  wire logic        control_modifier_key_i,
  input  wire logic        repeat_key_i,
  input  wire logic        auto_newline_switch_i,
  input  wire logic        lf_double_i,
  input  wire logic        inhibit_sw_i,
  input  wire logic        local_btn_i,
  input  wire logic        cts_i,
  input  wire logic        dsr_i,
  input  wire logic        rx_valid_i,
  input  wire logic [6:0]  rx_data_i,
  output logic             tx_valid_o,
  output logic      [6:0]  tx_data_o,
  input  wire logic        tx_ready_i,
  output logic             key_tone_o,
  output logic             alarm_o,
  output logic             motor_o,
  output logic             rts_o,
  output logic             dtr_o,
  output logic             ready_lamp_o,
  output logic             intr_lamp_o,
  output logic             print_suppress_o,
  output logic             xmit_mode_o,
  output logic      [6:0]  col_o,
  output logic             paper_adv_o,
  output logic      [1:0]  paper_lines_o,
  output logic             vtab_o,
  output logic             form_feed_o,
  output logic             reader_rev_o
);
  typedef struct packed {
    logic [PW-1:0]     s1;
    logic [PW-1:0]     s2;
    logic [PW-1:0]     s3;
    logic [PW-1:0]     flt;
    logic              down_q;
    logic              cts_q;
    logic              ack;
    logic [31:0]       dat;
    logic [CTRL_W-1:0] ctrl;
    logic [6:0]        col;
    logic [NCOL-1:0]   tabs;
    logic              esc_rx;
    logic              dle_rx;
    logic              dle_loc;
    logic              motor;
    logic              rts;
    logic              dtr;
    logic              ready;
    logic              intr;
    logic              kbd_off;
    logic              supp;
    logic              xmit;
    logic [31:0]       alarm_cnt;
    logic              alarm;
    logic [31:0]       rpt_cnt;
    logic              key_pend;
    logic              tone;
    logic              adv;
    logic [1:0]        lines;
    logic              vt;
    logic              ff;
    logic              rrev;
    logic              enq_pend;
    logic              ab_pend;
    logic              stat_pend;
    logic              txv;
    logic [6:0]        txd;
    logic [6:0]        tx2;
    tcc_tx_t           txs;
    logic [4:0]        midx;
  } tcc_state_t;

  tcc_state_t st_r;
  tcc_state_t st_nxt;

  logic [PW-1:0] pins;
  logic [6:0]    msg_q;
  logic [6:0]    k;
  logic [6:0]    c;
  logic [31:0]   stat_word;
  logic [4:0]    msg_len;
  logic          press;
  logic          can_key;
  logic          ev;
  logic          ev_rx;
  logic          esc_c;
  logic          dle_c;
  logic          loc_lf;
  logic          wr;
  logic          mem_we;
  logic          ta;
  logic          strap;

  function automatic logic [6:0] next_tab(input logic [NCOL-1:0] t, input logic [6:0] p);
    logic [6:0] r;
    r = COL_LAST;
    for (int i = NCOL - 1; i >= 0; i--) begin
      if (t[i] && 7'(i) > p) r = 7'(i);
    end
    return r;
  endfunction

  function automatic logic [6:0] left_margin(input logic [NCOL-1:0] t);
    logic [6:0] r;
    r = '0;
    for (int i = NCOL - 1; i >= 0; i--) begin
      if (t[i]) r = 7'(i);
    end
    return r;
  endfunction

  assign pins = {dsr_i, cts_i, local_btn_i, inhibit_sw_i, lf_double_i,
                 auto_newline_switch_i, repeat_key_i, control_modifier_key_i,
                 esc_key_i, key_down_i, key_code_i};
  assign msg_len = st_r.ctrl[MLEN_LO +: 5];
  assign ta = st_r.ctrl[B_TA];
  assign strap = st_r.ctrl[B_STRAP];
  assign wr = wb_cyc_i & wb_stb_i & ~st_r.ack & wb_we_i;
  assign mem_we = wr && wb_adr_i == A_MSG && wb_sel_i[1:0] == 2'b11;
  assign stat_word = {15'h0000, st_r.kbd_off, st_r.alarm, st_r.xmit, st_r.supp,
                      st_r.intr, st_r.ready, st_r.dtr, st_r.rts, st_r.motor,
                      1'b0, st_r.col};

  tcc_msg_mem u_msg (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (mem_we),
    .waddr_i (wb_dat_i[M_IDX_LO +: 5]),
    .wdata_i (wb_dat_i[6:0]),
    .raddr_i (st_r.midx),
    .rdata_o (msg_q)
  );

  always_comb begin
    st_nxt = st_r;
    press = 1'b0;
    can_key = 1'b0;
    ev = 1'b0;
    ev_rx = 1'b0;
    esc_c = 1'b0;
    dle_c = 1'b0;
    loc_lf = 1'b0;
    c = '0;
    // three-stage pin sync; a change counts once stages two and three agree
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.flt = (st_r.s3 & ~(st_r.s2 ^ st_r.s3)) | (st_r.flt & (st_r.s2 ^ st_r.s3));
    st_nxt.down_q = st_r.flt[P_DOWN];
    st_nxt.cts_q = st_r.flt[P_CTS];
    st_nxt.tone = 1'b0;
    st_nxt.adv = 1'b0;
    st_nxt.vt = 1'b0;
    st_nxt.ff = 1'b0;
    st_nxt.rrev = 1'b0;

    // bus slave: ack one cycle after the strobe, unmapped reads give zero
    st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
    st_nxt.dat = '0;
    if (st_nxt.ack && !wb_we_i) begin
      case (wb_adr_i)
        A_CTRL: st_nxt.dat = 32'(st_r.ctrl);
        A_STAT: st_nxt.dat = stat_word;
        default: st_nxt.dat = '0;
      endcase
    end
    if (wr && wb_adr_i == A_CTRL) begin
      if (wb_sel_i[0]) st_nxt.ctrl[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1]) st_nxt.ctrl[CTRL_W-1:8] = wb_dat_i[CTRL_W-1:8];
    end
    // clear first, so a NAK in the same cycle still lights the lamp
    if (wr && wb_adr_i == A_STAT && wb_sel_i[1] && wb_dat_i[S_CLR]) begin
      st_nxt.intr = 1'b0;
      st_nxt.kbd_off = 1'b0;
    end

    if (st_r.flt[P_INH] || st_r.flt[P_LOC]) st_nxt.supp = 1'b0; // R20
    if (st_r.flt[P_CTS] && !st_r.cts_q) st_nxt.ready = 1'b1;
    if (!st_r.flt[P_DSR]) st_nxt.dtr = 1'b1; // R16
    if (st_r.alarm_cnt != '0) st_nxt.alarm_cnt = st_r.alarm_cnt - 32'h1;
    if (st_r.txv && tx_ready_i) st_nxt.txv = 1'b0;

    // keyboard: escape, control and repeat keys are not key_down presses
    press = st_r.flt[P_DOWN] & ~st_r.down_q;
    if (press) begin
      st_nxt.key_pend = 1'b1;
      st_nxt.tone = 1'b1; // R2
    end
    if (st_r.flt[P_RPT] && st_r.flt[P_DOWN]) begin
      if (st_r.rpt_cnt == 32'h1) st_nxt.key_pend = 1'b1; // R4
      if (st_r.rpt_cnt != '0) st_nxt.rpt_cnt = st_r.rpt_cnt - 32'h1;
    end else begin
      st_nxt.rpt_cnt = '0;
    end
    if (st_r.kbd_off) st_nxt.key_pend = 1'b0; // R18
    k = st_r.flt[P_CTL] ? (st_r.flt[P_CODE +: 7] & CTL_MASK)
                        : st_r.flt[P_CODE +: 7]; // R3
    // one code in flight at a time; queued replies go first
    can_key = st_r.key_pend & (st_r.txs == TX_IDLE) & ~st_r.txv & ~rx_valid_i
            & ~st_r.enq_pend & ~st_r.ab_pend & ~st_r.stat_pend; // R1

    if (rx_valid_i) begin
      ev = 1'b1;
      ev_rx = 1'b1;
      c = rx_data_i;
      esc_c = st_r.esc_rx;
      dle_c = st_r.dle_rx;
      st_nxt.esc_rx = 1'b0;
      st_nxt.dle_rx = 1'b0;
    end else if (can_key) begin
      ev = 1'b1;
      c = k;
      esc_c = st_r.flt[P_ESC];
      dle_c = st_r.dle_loc;
      st_nxt.dle_loc = 1'b0;
      st_nxt.key_pend = 1'b0;
      st_nxt.rpt_cnt = 32'(RPT_CYC); // R4
      st_nxt.txv = 1'b1;
      st_nxt.rts = 1'b1;
      if (st_r.flt[P_ESC]) begin
        st_nxt.txd = C_ESC; // R3
        st_nxt.tx2 = k;
        st_nxt.txs = TX_SECOND;
      end else begin
        st_nxt.txd = k;
        if (k == C_CR && st_r.flt[P_AUTO]) begin
          st_nxt.tx2 = C_LF; // R5
          st_nxt.txs = TX_SECOND;
          loc_lf = 1'b1;
        end
      end
    end

    if (ev) begin
      if (esc_c) begin
        case (c)
          C_0: st_nxt.rrev = 1'b1; // R19
          C_1: if (st_r.ctrl[B_TAB]) st_nxt.tabs[st_r.col] = 1'b1; // R19
          C_2: if (st_r.ctrl[B_TAB]) st_nxt.tabs = '0; // R19
          C_SEM: if (ev_rx || strap) st_nxt.supp = 1'b1; // R20
          C_COL: if (ev_rx) st_nxt.supp = 1'b0; // R20
          C_UH, C_LH: if (ev_rx || strap) st_nxt.motor = 1'b1; // R21
          C_UJ, C_LJ: if (ev_rx || strap) st_nxt.motor = 1'b0; // R21
          default: ; // R6
        endcase
      end else if (dle_c && c == C_EOT && ta) begin
        st_nxt.dtr = 1'b0; // R16
        st_nxt.motor = 1'b0;
      end else if (dle_c && c == C_QM && ev_rx) begin
        st_nxt.supp = 1'b1; // R17
        st_nxt.ready = 1'b0;
        st_nxt.enq_pend = 1'b1;
      end else begin
        case (c)
          C_ESC: if (ev_rx) st_nxt.esc_rx = 1'b1;
          C_DLE: begin
            if (ev_rx) st_nxt.dle_rx = 1'b1;
            else st_nxt.dle_loc = 1'b1;
          end
          C_ETX: if (ta && (ev_rx != st_r.xmit)) st_nxt.xmit = ev_rx; // R7
          C_EOT: begin
            if (st_r.ctrl[B_EOT]) begin
              st_nxt.motor = 1'b0; // R8
              st_nxt.rts = 1'b0;
            end
          end
          C_ENQ: begin
            if (ev_rx && st_r.flt[P_CTS]) begin
              st_nxt.ab_pend = st_r.ctrl[B_AB]; // R9
              st_nxt.stat_pend = ta;
            end
          end
          C_ACK: if (ta) st_nxt.xmit = ~st_r.xmit; // R10
          C_NAK: begin
            if (ta && ev_rx) begin
              st_nxt.xmit = ~st_r.xmit; // R18
              st_nxt.intr = 1'b1;
              st_nxt.kbd_off = 1'b1;
            end
          end
          // a bell during the tone leaves the count alone
          C_BEL: if (st_r.alarm_cnt == '0) st_nxt.alarm_cnt = 32'(ALARM_CYC); // R11
          C_BS: if (st_r.col != '0) st_nxt.col = st_r.col - COL_STEP; // R12
          C_HT: if (st_r.ctrl[B_TAB]) st_nxt.col = next_tab(st_r.tabs, st_r.col); // R13
          C_LF: begin
            st_nxt.adv = 1'b1; // R14
            st_nxt.lines = st_r.flt[P_LF2] ? LINES_2 : LINES_1;
          end
          C_VT: if (st_r.ctrl[B_VT]) st_nxt.vt = 1'b1; // R14
          C_FF: if (st_r.ctrl[B_VT]) st_nxt.ff = 1'b1; // R14
          C_CR: st_nxt.col = st_r.ctrl[B_TAB] ? left_margin(st_r.tabs) : '0; // R15
          default: begin
            // printable graphics advance the column unless locally suppressed
            if (c >= C_SP && c != C_DEL && (ev_rx || !st_r.supp)
                && st_r.col != COL_LAST) begin
              st_nxt.col = st_r.col + COL_STEP;
            end
          end
        endcase
      end
      if (loc_lf) begin
        st_nxt.adv = 1'b1; // R5
        st_nxt.lines = st_r.flt[P_LF2] ? LINES_2 : LINES_1;
      end
    end

    case (st_r.txs)
      TX_IDLE: begin
        if (!st_r.txv) begin
          if (st_r.enq_pend) begin
            st_nxt.enq_pend = 1'b0;
            st_nxt.txv = 1'b1;
            st_nxt.txd = C_ENQ; // R17
          end else if (st_r.ab_pend) begin
            st_nxt.ab_pend = 1'b0;
            st_nxt.midx = '0;
            st_nxt.txs = TX_MSG; // R9
          end else if (st_r.stat_pend) begin
            st_nxt.stat_pend = 1'b0;
            st_nxt.txv = 1'b1;
            st_nxt.txd = st_r.ctrl[B_OK] ? C_ACK : C_NAK; // R10
            st_nxt.xmit = ~st_nxt.xmit; // R9
          end
        end
      end
      TX_SECOND: begin
        if (!st_r.txv) begin
          st_nxt.txv = 1'b1;
          st_nxt.txd = st_r.tx2;
          st_nxt.txs = TX_IDLE;
        end
      end
      TX_MSG: begin
        if (st_r.midx >= msg_len || st_r.midx == MSG_MAX) st_nxt.txs = TX_IDLE;
        else if (!st_r.txv) st_nxt.txs = TX_LOAD;
      end
      TX_LOAD: begin
        st_nxt.txv = 1'b1;
        st_nxt.txd = msg_q;
        st_nxt.midx = st_r.midx + MIDX_STEP;
        st_nxt.txs = TX_MSG;
      end
      default: st_nxt.txs = TX_IDLE;
    endcase
    st_nxt.alarm = st_nxt.alarm_cnt != '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0; // R23
      st_r.ctrl <= CTRL_RST;
      st_r.dtr <= 1'b1;
      st_r.txs <= TX_IDLE;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.dat;
  assign wb_ack_o = st_r.ack;
  assign tx_valid_o = st_r.txv;
  assign tx_data_o = st_r.txd;
  assign key_tone_o = st_r.tone;
  assign alarm_o = st_r.alarm;
  assign motor_o = st_r.motor;
  assign rts_o = st_r.rts;
  assign dtr_o = st_r.dtr;
  assign ready_lamp_o = st_r.ready;
  assign intr_lamp_o = st_r.intr;
  assign print_suppress_o = st_r.supp;
  assign xmit_mode_o = st_r.xmit;
  assign col_o = st_r.col;
  assign paper_adv_o = st_r.adv;
  assign paper_lines_o = st_r.lines;
  assign vtab_o = st_r.vt;
  assign form_feed_o = st_r.ff;
  assign reader_rev_o = st_r.rrev;
endmodule // tcc_top
`default_nettype wire

/* File: testbench/tcc_host_model.sv */
// far-side host: takes every transmitted character into a queue
// assumes the bench raises stall_i to hold off the link
`timescale 1ns/1ps
`default_nettype none
module tcc_host_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       stall_i,
  input  wire logic       tx_valid_i,
  input  wire logic [6:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [6:0] got_q[$];

  // ready is registered, so a stall lands one cycle late as on a real link
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= !stall_i;
      if (tx_valid_i && tx_ready_o) begin
        got_q.push_back(tx_data_i);
      end
    end
  end
endmodule  // tcc_host_model
`default_nettype wire

/* File: testbench/tcc_top_assertions.sv */
// port-level checker for the control code interpreter
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tcc_top_assertions
  import tcc_pkg::*;
#(
  parameter int unsigned ALARM_CYC = 50
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        rx_valid_i,
  input wire logic [6:0]  rx_data_i,
  input wire logic        tx_valid_o,
  input wire logic [6:0]  tx_data_o,
  input wire logic        tx_ready_i,
  input wire logic        key_tone_o,
  input wire logic        alarm_o,
  input wire logic        lf_double_i,
  input wire logic [6:0]  col_o,
  input wire logic        paper_adv_o,
  input wire logic [1:0]  paper_lines_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic [31:0] alarm_cnt_r;
  // length of the current tone; a retrigger would push it past the limit
  always_ff @(posedge clk_i) begin
    if (rst_i || !alarm_o) begin
      alarm_cnt_r <= 32'h0;
    end else begin
      alarm_cnt_r <= alarm_cnt_r + 32'h1;
    end
  end

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held too long");
  ack_answer_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("transmit character dropped or changed while waiting");
  col_range_a: assert property (col_o <= COL_LAST)
    else $error("print column beyond line end");
  bs_step_a: assert property (rx_valid_i && rx_data_i == C_BS && col_o != 7'h00
      |=> col_o == $past(col_o) - COL_STEP)
    else $error("backspace did not step one column");
  lf_adv_a: assert property (rx_valid_i && rx_data_i == C_LF
      && $past(lf_double_i, 3) == $past(lf_double_i, 4)
      |=> paper_adv_o && paper_lines_o == ($past(lf_double_i, 5) ? LINES_2 : LINES_1))
    else $error("line feed advance wrong");
  bel_start_a: assert property (rx_valid_i && rx_data_i == C_BEL && !alarm_o |=> alarm_o)
    else $error("bell did not start alarm");
  alarm_len_a: assert property (alarm_cnt_r <= ALARM_CYC)
    else $error("alarm tone too long");
  tone_pulse_a: assert property (key_tone_o |=> !key_tone_o)
    else $error("key tone longer than one cycle");
endmodule  // tcc_top_assertions

bind tcc_top tcc_top_assertions #(.ALARM_CYC(ALARM_CYC)) u_chk (
  .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .rx_valid_i, .rx_data_i,
  .tx_valid_o, .tx_data_o, .tx_ready_i, .key_tone_o, .alarm_o, .lf_double_i, .col_o,
  .paper_adv_o, .paper_lines_o
);
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench: bus, received control codes and keyboard
// assumes tcc_host_model as far side and the bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tcc_pkg::*;
  localparam int unsigned AC = 50;
  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, key_down_i = 1'b0, esc_key_i = 1'b0, control_modifier_key_i = 1'b0;
  logic repeat_key_i = 1'b0, auto_newline_switch_i = 1'b0, lf_double_i = 1'b0;
  logic inhibit_sw_i = 1'b0, local_btn_i = 1'b0, cts_i = 1'b0, dsr_i = 1'b0;
  logic rx_valid_i = 1'b0, stall = 1'b0, x;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, rd;
  logic [3:0] wb_sel_i = 4'hF;
  logic [6:0] key_code_i = 7'h00, rx_data_i = 7'h00;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, tx_valid_o, tx_ready_i, key_tone_o, alarm_o, motor_o, rts_o, dtr_o;
  logic ready_lamp_o, intr_lamp_o, print_suppress_o, xmit_mode_o, paper_adv_o;
  logic vtab_o, form_feed_o, reader_rev_o;
  logic [6:0] tx_data_o, col_o;
  logic [1:0] paper_lines_o;
  int error_cnt = 0, compares = 0, n;

  tcc_top #(.ALARM_CYC(AC), .RPT_CYC(4)) i_dut (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
    .wb_dat_o, .wb_ack_o, .key_code_i, .key_down_i, .esc_key_i, .control_modifier_key_i,
    .repeat_key_i, .auto_newline_switch_i, .lf_double_i, .inhibit_sw_i, .local_btn_i,
    .cts_i, .dsr_i, .rx_valid_i, .rx_data_i, .tx_valid_o, .tx_data_o, .tx_ready_i,
    .key_tone_o, .alarm_o, .motor_o, .rts_o, .dtr_o, .ready_lamp_o, .intr_lamp_o,
    .print_suppress_o, .xmit_mode_o, .col_o, .paper_adv_o, .paper_lines_o, .vtab_o,
    .form_feed_o, .reader_rev_o);
  tcc_host_model i_host (.clk_i, .rst_i, .stall_i(stall), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));

  initial forever #4 clk_i = ~clk_i;

  task automatic results();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
    k = 0;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    if (k >= 20) begin error_cnt++; results(); end
  endtask
  task automatic rx(input logic [6:0] c);
    @(posedge clk_i);
    rx_valid_i <= 1'b1; rx_data_i <= c;
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    #1;
  endtask
  // key held long enough for the pin filter, then released
  task automatic press(input logic [6:0] c, input logic e, input logic k);
    int t;
    t = 0;
    @(posedge clk_i);
    key_code_i <= c; esc_key_i <= e; control_modifier_key_i <= k; key_down_i <= 1'b1;
    repeat (12) begin @(posedge clk_i); #1; if (key_tone_o === 1'b1) t++; end
    @(posedge clk_i);
    key_down_i <= 1'b0; esc_key_i <= 1'b0; control_modifier_key_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(t, 1);
  endtask
  task automatic txq(input logic [6:0] c);
    int k;
    k = 0;
    while (i_host.got_q.size() == 0 && k < 60) begin @(posedge clk_i); k++; end
    if (k >= 60) begin error_cnt++; results(); end
    chk(i_host.got_q.pop_front(), c);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk({dtr_o, motor_o, col_o}, {1'b1, 1'b0, 7'h00});
    wb(1'b0, A_CTRL, 32'h0); chk(rd, {19'h0, CTRL_RST});
    wb(1'b0, 8'h40, 32'h0); chk(rd, 32'h0);
    stall <= 1'b1;  // hold the link so the first key waits
    press(7'h61, 1'b0, 1'b0);
    stall <= 1'b0;
    txq(7'h61);
    press(7'h65, 1'b0, 1'b1); txq(7'h65 & CTL_MASK);
    press(C_UH, 1'b1, 1'b0); txq(C_ESC); txq(C_UH);
    chk(motor_o, 1'b0);
    auto_newline_switch_i <= 1'b1;
    press(C_CR, 1'b0, 1'b0); txq(C_CR); txq(C_LF);
    auto_newline_switch_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    press(C_CR, 1'b0, 1'b0); txq(C_CR);
    repeat_key_i <= 1'b1; press(7'h62, 1'b0, 1'b0); repeat (3) txq(7'h62);
    repeat_key_i <= 1'b0;
    rx(C_CR); repeat (3) rx(7'h41); chk(col_o, 7'h03);
    rx(C_HT); chk(col_o, 7'h03);
    rx(C_BS); chk(col_o, 7'h02);
    rx(C_CR); chk(col_o, 7'h00);
    rx(C_LF); chk({paper_adv_o, paper_lines_o}, {1'b1, LINES_1});
    lf_double_i <= 1'b1; repeat (6) @(posedge clk_i);
    rx(C_LF); chk({paper_adv_o, paper_lines_o}, {1'b1, LINES_2});
    rx(C_BEL); chk(alarm_o, 1'b1); rx(C_BEL);
    n = 2;
    do begin @(posedge clk_i); #1; n++; end while (alarm_o === 1'b1 && n < 200);
    chk(n, AC);
    rx(C_ESC); rx(C_UH); chk(motor_o, 1'b1);
    repeat (4) @(posedge clk_i);
    rx(C_ESC); rx(C_UJ); chk(motor_o, 1'b0);
    chk(rts_o, 1'b1); rx(C_ESC); rx(C_UH); rx(C_EOT); chk({motor_o, rts_o}, 2'b00);
    rx(C_ESC); rx(C_SEM); chk(print_suppress_o, 1'b1);
    rx(C_ESC); rx(C_COL); chk(print_suppress_o, 1'b0);
    rx(C_ESC); rx(C_0); chk(reader_rev_o, 1'b1);
    wb(1'b1, A_CTRL, 32'h0000_016F); wb(1'b0, A_CTRL, 32'h0); chk(rd, 32'h0000_016F);
    rx(C_VT); chk(vtab_o, 1'b1); rx(C_FF); chk(form_feed_o, 1'b1);
    rx(C_DLE); rx(C_EOT); chk(dtr_o, 1'b0);
    wb(1'b1, A_MSG, 32'h0000_005A);
    repeat (5) rx(7'h41); rx(C_ESC); rx(C_1);
    rx(C_CR); chk(col_o, 7'h05);
    rx(C_HT); chk(col_o, COL_LAST);
    rx(C_ESC); rx(C_2); rx(C_CR); chk(col_o, 7'h00);
    cts_i <= 1'b1; repeat (6) @(posedge clk_i);
    chk(ready_lamp_o, 1'b1);
    rx(C_ENQ); txq(7'h5A); txq(C_ACK);
    x = xmit_mode_o;
    rx(C_ACK); chk(xmit_mode_o, !x);
    rx(C_DLE); rx(C_QM); txq(C_ENQ);
    chk({print_suppress_o, ready_lamp_o}, 2'b10);
    rx(C_NAK); chk(intr_lamp_o, 1'b1);
    wb(1'b0, A_STAT, 32'h0); chk({rd[16], rd[12]}, 2'b11);
    wb(1'b1, A_STAT, 32'h0000_1000); chk(intr_lamp_o, 1'b0);
    results();
  end
endmodule  // testbench
`default_nettype wire
